// ===== shared/card_seq_consts.svh
// Timing counts and reset values for the smartcard activation sequencer.
`ifndef CARD_SEQ_CONSTS_SVH
`define CARD_SEQ_CONSTS_SVH

// Half period of the card clock in system clock cycles, minus one.
`define SEQ_CLK_HALF_LAST     8'h18
// System clock cycles between supply enable and the first card clock edge.
`define SEQ_POWER_UP_CYCLES   16'h0010
// Card cycles after T0 at which the device stops driving the data line.
`define SEQ_DATA_HIGH_CYCLES  16'h00C8
// Card cycles that the reset stays low for an active-low-reset card.
`define SEQ_RESET_LOW_CYCLES  16'h9C40
// Earliest and latest card cycle at which an answer-to-reset is accepted.
`define SEQ_ATR_MIN_CYCLES    16'h0190
`define SEQ_ATR_MAX_CYCLES    16'h9C40
// Reset values of the card pins: unpowered, everything driven low.
`define SEQ_PINS_RESET        5'h00
`define SEQ_KILL_RESET        5'h00

`endif

// ===== shared/card_seq_pkg.sv
// Types shared by the smartcard activation sequencer.
package card_seq_pkg;

   // Activation side, system clock domain.
   typedef enum logic [2:0] {
      ACT_OFF,
      ACT_POWER_UP,
      ACT_RESET_LOW,
      ACT_WAIT_ATR,
      ACT_ACTIVE,
      ACT_DRAIN
   } act_state_t;

   // Deactivation side, slow reference clock domain.
   typedef enum logic [2:0] {
      DEACT_IDLE,
      DEACT_RESET_LOW,
      DEACT_CLOCK_STOP,
      DEACT_DATA_LOW,
      DEACT_POWER_OFF
   } deact_state_t;

   // Levels driven onto the card pins.
   typedef struct packed {
      logic supply;
      logic clock;
      logic reset;
      logic data;
      logic data_oe_n;
   } card_pins_t;

   // Deactivation steps in force, plus the cause of the sequence.
   typedef struct packed {
      logic cause_removal;
      logic power;
      logic data;
      logic clock;
      logic reset;
   } kill_t;

endpackage

// ===== src/level_sync.sv
// Two flip-flop synchroniser for a group of levels.
`timescale 1ns/10ps
module level_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_reg;

   // The first stage is read by the second stage only.
   always_ff @(posedge clock_i) begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
   end

endmodule

// ===== src/smartcard_activation_sequencer.sv
// Smartcard activation and deactivation sequencer.
`timescale 1ns/10ps
`include "card_seq_consts.svh"
module smartcard_activation_sequencer #(
   parameter logic [15:0] RESET_LOW_CYCLES = `SEQ_RESET_LOW_CYCLES,
   parameter logic [15:0] ATR_MIN_CYCLES   = `SEQ_ATR_MIN_CYCLES,
   parameter logic [15:0] ATR_MAX_CYCLES   = `SEQ_ATR_MAX_CYCLES
) (
   input  wire logic clock_i,
   input  wire logic rst_i,
   input  wire logic slow_reference_clock_i,
   input  wire logic activate_i,
   input  wire logic deactivate_i,
   input  wire logic active_low_reset_card_i,
   input  wire logic flag_clear_i,
   input  wire logic card_presence_detect_i,
   input  wire logic card_data_line_i,
   output logic      card_clock_out_o,
   output logic      card_reset_out_o,
   output logic      card_supply_enable_o,
   output logic      card_data_line_o,
   output logic      card_data_line_oe_n_o,
   output logic      card_active_o,
   output logic      atr_received_o,
   output logic      atr_timeout_o,
   output logic      removal_flag_o
);

   // System clock domain state.
   card_seq_pkg::act_state_t state_reg;
   card_seq_pkg::act_state_t state_next;
   card_seq_pkg::card_pins_t pins_reg;
   card_seq_pkg::card_pins_t pins_next;
   logic [7:0]               div_reg;
   logic [7:0]               div_next;
   logic [15:0]              cnt_reg;
   logic [15:0]              cnt_next;
   logic                     type_reg;
   logic                     type_next;
   logic                     act_reg;
   logic                     act_next;
   logic                     tgl_reg;
   logic                     tgl_next;
   logic                     rx_prev_reg;
   logic                     rx_prev_next;
   logic                     atr_reg;
   logic                     atr_next;
   logic                     tmo_reg;
   logic                     tmo_next;
   logic                     rem_reg;
   logic                     rem_next;

   // Signals crossing into the system clock domain, and decodes of the system-side state.
   card_seq_pkg::kill_t      kill_s;
   logic                     rx_s;
   logic                     running;
   logic                     clk_run;
   logic                     card_rise;
   logic                     rx_fall;

   // Slow reference clock domain state.
   card_seq_pkg::deact_state_t dstate_reg;
   card_seq_pkg::deact_state_t dstate_next;
   card_seq_pkg::kill_t        kill_reg;
   card_seq_pkg::kill_t        kill_next;
   logic                       seen_reg;
   logic                       seen_next;
   logic                       slow_rst_s;
   logic                       act_s;
   logic                       tgl_s;
   logic                       pd_s;
   logic                       cmd_trig;

   // Deactivation steps and card receive data, into the system domain.
   level_sync #(
      .WIDTH (5)
   ) u_kill_sync (
      .clock_i (clock_i),
      .async_i (kill_reg),
      .sync_o  (kill_s)
   );

   level_sync #(
      .WIDTH (1)
   ) u_rx_sync (
      .clock_i (clock_i),
      .async_i (card_data_line_i),
      .sync_o  (rx_s)
   );

   // Reset, card activity, command toggle and presence, into the slow domain.
   level_sync #(
      .WIDTH (1)
   ) u_rst_sync (
      .clock_i (slow_reference_clock_i),
      .async_i (rst_i),
      .sync_o  (slow_rst_s)
   );

   level_sync #(
      .WIDTH (3)
   ) u_slow_sync (
      .clock_i (slow_reference_clock_i),
      .async_i ({act_reg, tgl_reg, card_presence_detect_i}),
      .sync_o  ({act_s, tgl_s, pd_s})
   );

   // Card powered and under control of the activation sequence.
   assign running = (state_reg != card_seq_pkg::ACT_OFF) &&
                    (state_reg != card_seq_pkg::ACT_DRAIN);

   // The card clock runs from T0 until the deactivation stops it.
   assign clk_run = ((state_reg == card_seq_pkg::ACT_RESET_LOW) ||
                     (state_reg == card_seq_pkg::ACT_WAIT_ATR) ||
                     (state_reg == card_seq_pkg::ACT_ACTIVE)) &&
                    !kill_s.clock;

   // A rising card clock edge is due when the divider wraps with clock low.
   assign card_rise = clk_run && (div_reg == `SEQ_CLK_HALF_LAST) &&
                      !pins_reg.clock;

   // Start bit of the answer-to-reset once the device has let go of the line.
   assign rx_fall = rx_prev_reg && !rx_s && pins_reg.data_oe_n;

   // Next state of the activation sequence, card pins and status flags.
   always_comb begin
      state_next   = state_reg;
      pins_next    = pins_reg;
      div_next     = div_reg;
      cnt_next     = cnt_reg;
      type_next    = type_reg;
      act_next     = act_reg;
      tgl_next     = tgl_reg ^ (deactivate_i && running);
      rx_prev_next = rx_s;
      atr_next     = atr_reg;
      tmo_next     = flag_clear_i ? 1'b0 : tmo_reg;
      rem_next     = flag_clear_i ? 1'b0 : rem_reg;

      // Card clock divider and card cycle counter.
      if (clk_run) begin
         if (div_reg == `SEQ_CLK_HALF_LAST) begin
            div_next        = 8'h00;
            pins_next.clock = !pins_reg.clock;
         end else begin
            div_next = div_reg + 8'h01;
         end
      end else begin
         div_next        = 8'h00;
         pins_next.clock = 1'b0;
      end
      if (card_rise) begin
         cnt_next = cnt_reg + 16'h0001;
      end

      // Data line is driven high from T0 and let go before the answer window.
      if (running && !pins_reg.data_oe_n &&
          (cnt_reg >= `SEQ_DATA_HIGH_CYCLES)) begin
         pins_next.data_oe_n = 1'b1;
      end

      unique case (state_reg)
         card_seq_pkg::ACT_OFF: begin
            pins_next = `SEQ_PINS_RESET;
            if (activate_i && (kill_s == `SEQ_KILL_RESET)) begin
               pins_next.supply = 1'b1;
               type_next        = active_low_reset_card_i;
               act_next         = 1'b1;
               atr_next         = 1'b0;
               cnt_next         = 16'h0000;
               state_next       = card_seq_pkg::ACT_POWER_UP;
            end
         end
         card_seq_pkg::ACT_POWER_UP: begin
            cnt_next = cnt_reg + 16'h0001;
            if (cnt_reg == `SEQ_POWER_UP_CYCLES - 16'h0001) begin
               // T0: first card clock edge, data driven high at once.
               pins_next.clock     = 1'b1;
               pins_next.data      = 1'b1;
               pins_next.data_oe_n = 1'b0;
               pins_next.reset     = 1'b0;
               div_next            = 8'h00;
               cnt_next            = 16'h0000;
               state_next          = type_reg ?
                                     card_seq_pkg::ACT_RESET_LOW :
                                     card_seq_pkg::ACT_WAIT_ATR;
            end
         end
         card_seq_pkg::ACT_RESET_LOW: begin
            // Receive line is ignored while the reset is held low.
            if (card_rise && (cnt_reg == RESET_LOW_CYCLES - 16'h0001)) begin
               pins_next.reset = 1'b1;
               cnt_next        = 16'h0000;
               state_next      = card_seq_pkg::ACT_WAIT_ATR;
            end
         end
         card_seq_pkg::ACT_WAIT_ATR: begin
            if (kill_s == `SEQ_KILL_RESET) begin
               if (rx_fall && (cnt_reg >= ATR_MIN_CYCLES) &&
                   (cnt_reg <= ATR_MAX_CYCLES)) begin
                  atr_next   = 1'b1;
                  state_next = card_seq_pkg::ACT_ACTIVE;
               end else if (cnt_reg > ATR_MAX_CYCLES) begin
                  tmo_next   = 1'b1;
                  state_next = card_seq_pkg::ACT_ACTIVE;
               end
            end
         end
         card_seq_pkg::ACT_ACTIVE: begin
            cnt_next = cnt_reg;
         end
         card_seq_pkg::ACT_DRAIN: begin
            pins_next = `SEQ_PINS_RESET;
            if (!kill_s.power) begin
               state_next = card_seq_pkg::ACT_OFF;
            end
         end
      endcase

      // Deactivation steps override the activation outputs as they arrive.
      if (running) begin
         if (kill_s.reset) begin
            pins_next.reset = 1'b0;
         end
         if (kill_s.data) begin
            pins_next.data      = 1'b0;
            pins_next.data_oe_n = 1'b0;
         end
         if (kill_s.power) begin
            pins_next  = `SEQ_PINS_RESET;
            act_next   = 1'b0;
            state_next = card_seq_pkg::ACT_DRAIN;
            if (kill_s.cause_removal) begin
               rem_next = 1'b1;
            end
         end
      end
   end

   // System clock domain registers.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state_reg   <= card_seq_pkg::ACT_OFF;
         pins_reg    <= `SEQ_PINS_RESET;
         div_reg     <= 8'h00;
         cnt_reg     <= 16'h0000;
         type_reg    <= 1'b0;
         act_reg     <= 1'b0;
         tgl_reg     <= 1'b0;
         rx_prev_reg <= 1'b1;
         atr_reg     <= 1'b0;
         tmo_reg     <= 1'b0;
         rem_reg     <= 1'b0;
      end else begin
         state_reg   <= state_next;
         pins_reg    <= pins_next;
         div_reg     <= div_next;
         cnt_reg     <= cnt_next;
         type_reg    <= type_next;
         act_reg     <= act_next;
         tgl_reg     <= tgl_next;
         rx_prev_reg <= rx_prev_next;
         atr_reg     <= atr_next;
         tmo_reg     <= tmo_next;
         rem_reg     <= rem_next;
      end
   end

   // A command toggle that differs from the last one seen is a new request.
   assign cmd_trig = tgl_s ^ seen_reg;

   // Deactivation steps, one per slow reference clock period.
   always_comb begin
      dstate_next = dstate_reg;
      kill_next   = kill_reg;
      seen_next   = tgl_s;
      unique case (dstate_reg)
         card_seq_pkg::DEACT_IDLE: begin
            if (act_s && (cmd_trig || !pd_s)) begin
               kill_next.reset         = 1'b1;
               kill_next.cause_removal = !pd_s;
               dstate_next             = card_seq_pkg::DEACT_RESET_LOW;
            end
         end
         card_seq_pkg::DEACT_RESET_LOW: begin
            kill_next.clock = 1'b1;
            dstate_next     = card_seq_pkg::DEACT_CLOCK_STOP;
         end
         card_seq_pkg::DEACT_CLOCK_STOP: begin
            kill_next.data = 1'b1;
            dstate_next    = card_seq_pkg::DEACT_DATA_LOW;
         end
         card_seq_pkg::DEACT_DATA_LOW: begin
            kill_next.power = 1'b1;
            dstate_next     = card_seq_pkg::DEACT_POWER_OFF;
         end
         card_seq_pkg::DEACT_POWER_OFF: begin
            // Hold every step until the system side has seen the power off.
            if (!act_s) begin
               kill_next   = `SEQ_KILL_RESET;
               dstate_next = card_seq_pkg::DEACT_IDLE;
            end
         end
      endcase
   end

   // Slow reference clock domain registers.
   always_ff @(posedge slow_reference_clock_i) begin
      if (slow_rst_s) begin
         dstate_reg <= card_seq_pkg::DEACT_IDLE;
         kill_reg   <= `SEQ_KILL_RESET;
         seen_reg   <= 1'b0;
      end else begin
         dstate_reg <= dstate_next;
         kill_reg   <= kill_next;
         seen_reg   <= seen_next;
      end
   end

   // Outputs straight from the pin and status registers.
   assign card_clock_out_o      = pins_reg.clock;
   assign card_reset_out_o      = pins_reg.reset;
   assign card_supply_enable_o  = pins_reg.supply;
   assign card_data_line_o      = pins_reg.data;
   assign card_data_line_oe_n_o = pins_reg.data_oe_n;
   assign card_active_o         = act_reg;
   assign atr_received_o        = atr_reg;
   assign atr_timeout_o         = tmo_reg;
   assign removal_flag_o        = rem_reg;

endmodule

// ===== testbench/card_seq_monitor.sv
// Checker of the card pin sequencing, bound to the sequencer.
`timescale 1ns/10ps
module card_seq_monitor #(
   parameter logic [15:0] RESET_LOW_CYCLES = 16'h9c40,
   parameter logic [15:0] ATR_MIN_CYCLES   = 16'h0190,
   parameter logic [15:0] ATR_MAX_CYCLES   = 16'h9c40
) (
   input  wire logic clock_i,
   input  wire logic rst_i,
   input  wire logic card_presence_detect_i,
   input  wire logic card_clock_out_o,
   input  wire logic card_reset_out_o,
   input  wire logic card_supply_enable_o,
   input  wire logic card_data_line_o,
   input  wire logic card_data_line_oe_n_o,
   input  wire logic atr_received_o,
   input  wire logic atr_timeout_o,
   input  wire logic removal_flag_o
);
   logic [16:0] cnt_reg;
   logic [16:0] cnt_next;
   logic [5:0]  low_reg;
   logic [5:0]  low_next;
   logic        clk_reg;
   logic        sup_reg;
   logic        rel_reg;

   // Card clock rises since power-up or reset release, and the low run.
   always_comb begin
      cnt_next = cnt_reg + {16'h0000, card_clock_out_o & ~clk_reg};
      if ((card_supply_enable_o & ~sup_reg) |
          (card_reset_out_o & ~rel_reg)) begin
         cnt_next = 17'h0_0000;
      end
      low_next = card_clock_out_o ? 6'h00 : low_reg + {5'h00, ~&low_reg};
   end

   // Registers of the helper counts.
   always_ff @(posedge clock_i) begin
      cnt_reg <= rst_i ? 17'h0_0000 : cnt_next;
      low_reg <= rst_i ? 6'h00 : low_next;
      clk_reg <= card_clock_out_o;
      sup_reg <= card_supply_enable_o;
      rel_reg <= card_reset_out_o;
   end

   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);

   // Clock start instant, and the data line driven low while powered.
   sequence s_t0;
      $rose(card_supply_enable_o) ##16 1'b1;
   endsequence
   sequence s_dat_low;
      card_supply_enable_o && !card_data_line_oe_n_o && !card_data_line_o
         && $past(card_data_line_oe_n_o || card_data_line_o);
   endsequence

   property p_clock_start;
      $rose(card_supply_enable_o) |-> ##16 $rose(card_clock_out_o);
   endproperty
   property p_data_high;
      s_t0 |-> card_data_line_o && !card_data_line_oe_n_o;
   endproperty
   property p_reset_release;
      $rose(card_reset_out_o) |->
         cnt_reg inside {[RESET_LOW_CYCLES - 1 : RESET_LOW_CYCLES + 2]};
   endproperty
   property p_atr_window;
      $rose(atr_received_o) |->
         cnt_reg inside {[ATR_MIN_CYCLES : ATR_MAX_CYCLES + 2]};
   endproperty
   property p_atr_timeout;
      $rose(atr_timeout_o) |->
         cnt_reg inside {[ATR_MAX_CYCLES : ATR_MAX_CYCLES + 2]};
   endproperty
   property p_clock_stop;
      s_dat_low |-> low_reg >= 6'h1c;
   endproperty
   property p_data_low;
      $fell(card_reset_out_o) |-> ##[56:69] s_dat_low;
   endproperty
   property p_supply_off;
      s_dat_low |-> card_supply_enable_o[*8] ##[21:28] !card_supply_enable_o;
   endproperty
   property p_removal;
      $fell(card_presence_detect_i) && card_reset_out_o |->
         ##[1:160] $fell(card_reset_out_o);
   endproperty
   property p_removal_flag;
      $rose(removal_flag_o) |->
         !card_supply_enable_o && !card_presence_detect_i;
   endproperty

   a_clock_start: assert property (p_clock_start)
      else $error("card clock did not start on time");
   a_data_high: assert property (p_data_high)
      else $error("data line not driven high at clock start");
   a_reset_release: assert property (p_reset_release)
      else $error("card reset released at the wrong count");
   a_atr_window: assert property (p_atr_window)
      else $error("answer accepted outside its window");
   a_atr_timeout: assert property (p_atr_timeout)
      else $error("answer timeout at the wrong count");
   a_clock_stop: assert property (p_clock_stop)
      else $error("card clock still running at data low");
   a_data_low: assert property (p_data_low)
      else $error("data low not two slow periods after reset low");
   a_supply_off: assert property (p_supply_off)
      else $error("supply drop not one slow period after data low");
   a_removal: assert property (p_removal)
      else $error("removal did not drive card reset low");
   a_removal_flag: assert property (p_removal_flag)
      else $error("removal flag set without a removal power-off");
endmodule

bind smartcard_activation_sequencer card_seq_monitor #(
   .RESET_LOW_CYCLES(RESET_LOW_CYCLES),
   .ATR_MIN_CYCLES  (ATR_MIN_CYCLES),
   .ATR_MAX_CYCLES  (ATR_MAX_CYCLES)
) mon (
   .clock_i               (clock_i),
   .rst_i                 (rst_i),
   .card_presence_detect_i(card_presence_detect_i),
   .card_clock_out_o      (card_clock_out_o),
   .card_reset_out_o      (card_reset_out_o),
   .card_supply_enable_o  (card_supply_enable_o),
   .card_data_line_o      (card_data_line_o),
   .card_data_line_oe_n_o (card_data_line_oe_n_o),
   .atr_received_o        (atr_received_o),
   .atr_timeout_o         (atr_timeout_o),
   .removal_flag_o        (removal_flag_o)
);

// ===== testbench/card_model.sv
// Behavioural model of the smartcard on the far side of the pins.
`timescale 1ns/10ps
module card_model #(
   parameter int ANSWER_AT = 220
) (
   input  wire logic card_clock_i,
   input  wire logic card_reset_i,
   input  wire logic supply_i,
   input  wire logic data_drive_i,
   input  wire logic data_oe_n_i,
   input  wire logic answer_en_i,
   input  wire logic active_low_i,
   output logic      line_o
);
   int   cnt = 0;
   logic last_rst = 1'b0;
   logic pull;

   // Counts card clock rises since clock start or reset release.
   always @(posedge card_clock_i) begin
      if (card_reset_i !== last_rst) begin
         cnt = 0;
      end
      last_rst = card_reset_i;
      cnt = cnt + 1;
   end

   // A power drop restarts the count for the next activation.
   always @(negedge supply_i) begin
      cnt = 0;
      last_rst = 1'b0;
   end

   // An active-low-reset card is silent while its reset is low; answers once by pulling the line low.
   assign pull = answer_en_i && supply_i && (!active_low_i || card_reset_i)
                 && cnt >= ANSWER_AT && cnt < ANSWER_AT + 4;
   // The wire has a pull-up, so it reads high unless someone pulls it.
   assign line_o = !data_oe_n_i ? data_drive_i : !pull;
endmodule

// ===== testbench/smartcard_activation_sequencer_bench.sv
// Self-checking bench of the smartcard activation sequencer.
`timescale 1ns/10ps
module smartcard_activation_sequencer_bench;
   logic                     clock_i = 1'b0;
   logic                     rst_i = 1'b1;
   logic                     slow_clk = 1'b0;
   logic                     activate = 1'b0;
   logic                     deactivate = 1'b0;
   logic                     active_low = 1'b0;
   logic                     flag_clear = 1'b0;
   logic                     presence = 1'b1;
   logic                     answer_en = 1'b0;
   logic                     line;
   logic                     clk_o, rst_o, sup_o, dat_o, oe_n_o;
   logic                     act_o, rcv_o, to_o, rem_o;
   logic                     prev_act = 1'b0;
   logic [2:0]               prev_flags = 3'h0;
   logic [2:0]               flag_q[$];
   card_seq_pkg::card_pins_t pin_q[$];
   int                       err_count = 0;
   int                       num_checks = 0;
   int                       seed = 32'h0000_9b56;

   smartcard_activation_sequencer #(
      .RESET_LOW_CYCLES(16'h00fa),
      .ATR_MIN_CYCLES  (16'h000a),
      .ATR_MAX_CYCLES  (16'h012c)
   ) dut (
      .clock_i               (clock_i),
      .rst_i                 (rst_i),
      .slow_reference_clock_i(slow_clk),
      .activate_i            (activate),
      .deactivate_i          (deactivate),
      .active_low_reset_card_i(active_low),
      .flag_clear_i          (flag_clear),
      .card_presence_detect_i(presence),
      .card_data_line_i      (line),
      .card_clock_out_o      (clk_o),
      .card_reset_out_o      (rst_o),
      .card_supply_enable_o  (sup_o),
      .card_data_line_o      (dat_o),
      .card_data_line_oe_n_o (oe_n_o),
      .card_active_o         (act_o),
      .atr_received_o        (rcv_o),
      .atr_timeout_o         (to_o),
      .removal_flag_o        (rem_o)
   );

   card_model card (
      .card_clock_i(clk_o),
      .card_reset_i(rst_o),
      .supply_i    (sup_o),
      .data_drive_i(dat_o),
      .data_oe_n_i (oe_n_o),
      .answer_en_i (answer_en),
      .active_low_i(active_low),
      .line_o      (line)
   );

   // System clock at 250 MHz and an unrelated slow reference clock.
   always #2 clock_i = ~clock_i;
   initial begin
      #13.3;
      forever #62.5 slow_clk = ~slow_clk;
   end

   task automatic check_flags(input logic [2:0] exp, input logic [2:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: flags exp %h got %h", $time, exp, got);
      end
   endtask

   task automatic check_pins(input card_seq_pkg::card_pins_t exp,
                             input card_seq_pkg::card_pins_t got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: pins exp %h got %h", $time, exp, got);
      end
   endtask

   // Takes the oldest note whenever a flag rises or the card powers off.
   always @(posedge clock_i) begin
      #1;
      if (|({rcv_o, to_o, rem_o} & ~prev_flags)) begin
         check_flags(flag_q.size() ? flag_q.pop_front() : 3'hx,
                     {rcv_o, to_o, rem_o});
      end
      if (prev_act && act_o === 1'b0) begin
         check_pins(pin_q.size() ? pin_q.pop_front() : 5'hx,
                    {sup_o, clk_o, rst_o, dat_o, oe_n_o});
      end
      prev_flags = {rcv_o, to_o, rem_o};
      prev_act = act_o;
   end

   task automatic start(input logic al, input logic ans);
      @(posedge clock_i);
      active_low <= al;
      answer_en <= ans;
      activate <= 1'b1;
      @(posedge clock_i);
      activate <= 1'b0;
      repeat (2) @(posedge clock_i);
   endtask

   task automatic pulse(input bit clr);
      @(posedge clock_i);
      if (clr) flag_clear <= 1'b1;
      else deactivate <= 1'b1;
      @(posedge clock_i);
      flag_clear <= 1'b0;
      deactivate <= 1'b0;
   endtask

   task automatic wait_for(input bit off, input int limit);
      int i;
      for (i = 0; i < limit; i++) begin
         @(posedge clock_i);
         if ((off ? ~act_o : rcv_o | to_o) === 1'b1) break;
      end
      if (i == limit) begin
         err_count++;
         $display("mismatch at %0t: wait exp %h got %h", $time, 1'b1, 1'b0);
      end
   endtask

   // Waits for power-off, refits the card and lets the slow side settle.
   task automatic finish_off(input int n);
      wait_for(1, 2000);
      presence <= 1'b1;
      repeat (4) @(posedge slow_clk);
      $display("test %0d done", n);
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Main sequence: answer, removal, timeout, then random deactivations.
   initial begin
      repeat (4) @(posedge slow_clk);
      @(posedge clock_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge slow_clk);
      pulse(0);
      flag_q.push_back(3'h4);
      start(1'b0, 1'b1);
      wait_for(0, 20000);
      pin_q.push_back(5'h00);
      pulse(0);
      finish_off(1);
      flag_q.push_back(3'h4);
      flag_q.push_back(3'h5);
      pin_q.push_back(5'h00);
      start(1'b1, 1'b1);
      wait_for(0, 40000);
      presence <= 1'b0;
      finish_off(2);
      pulse(1);
      flag_q.push_back(3'h2);
      pin_q.push_back(5'h00);
      start(1'b0, 1'b0);
      wait_for(0, 20000);
      pulse(1);
      pulse(0);
      finish_off(3);
      for (int k = 0; k < 3; k++) begin
         start(1'($random(seed)), 1'b1);
         repeat ($unsigned($random(seed)) % 8000) @(posedge clock_i);
         pin_q.push_back(5'h00);
         pulse(0);
         finish_off(4 + k);
      end
      end_of_test();
   end

   // Watchdog well beyond the expected run length.
   initial begin
      #600000;
      err_count++;
      $display("mismatch at %0t: run exp %h got %h", $time, 1'b0, 1'b1);
      end_of_test();
   end
endmodule
